// ===== core/ssr_shadow_regs.sv
// What this block does
// - Command write starts execution at once
// - Any command-block write clears high-byte select
// - Interrupt gated by disable bit and selection
// - Software reset holds device busy
// - Device/head bit 6 selects CHS or LBA
// - Device/head bit 4 selects device number
// - Head bits carry and report address 24-27 for 28-bit commands
// - Error bit 7 flags link CRC error
// - Error bit 6 flags uncorrectable data
// - Error bit 2 flags aborted command
// - Address registers report current address at end
// - Address registers keep previous write for 48-bit
// - Zero count means 256 or 65,536 sectors
// - Count reads zero on success, else remainder
// - Status updates on error/end; read acknowledges
// - While busy reads give status, command-block writes ignored
// - Ready bit low until power-on settle ends; commands are not held off
// - Fault bit set on write fault, cleared by a status read while not busy
// - Corrected-data bit always reads zero
// - Error bit cleared when next command arrives
`timescale 1ns/100ps
`default_nettype none
module ssr_shadow_regs #(
    parameter logic DEVICE_NUMBER = 1'b0
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    // Host register port
    input  wire ssr_pkg::ssr_hbus_t    hbus,
    output logic                 [7:0] host_rdata_r,
    output logic                       intrq,
    output logic                       frame_i_bit,
    // Command engine side
    output logic                       cmd_start_r,
    output ssr_pkg::ssr_cmd_t          cmd_r,
    output logic                       soft_reset,
    input  wire logic                  drq_in,
    input  wire ssr_pkg::ssr_result_t  result
);
    import ssr_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] devhead_r;
    logic       hob_r;
    logic       software_reset_bit_r;
    logic       software_reset_bit_d_r;
    logic       interrupt_disable_r;
    logic       busy_r;
    logic       df_r;
    logic       err_r;
    logic       irq_pend_r;
    logic [7:0] error_r;
    logic       last_ext_r;

    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] low_cur;
    logic [7:0] low_prev;
    logic [7:0] mid_cur;
    logic [7:0] mid_prev;
    logic [7:0] high_cur;
    logic [7:0] high_prev;
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic       ready;

    // ************************************************************
    // Access decode
    // ************************************************************
    logic       cb_wr;
    logic       cb_rd;
    logic       ctl_wr;
    logic       cmd_wr;
    logic       selected;
    logic       status_rd;
    logic       cmd_ext;
    logic [7:0] status_byte;
    logic       ld_en;
    logic       ld_prev;

    // Busy masks every command-block write; control stays writable so reset works
    assign cb_wr     = hbus.wr && !hbus.ctl_sel && !busy_r;
    assign cb_rd     = hbus.rd && !hbus.ctl_sel;
    assign ctl_wr    = hbus.wr && hbus.ctl_sel && (hbus.addr == SSR_IDX_CTL);
    assign selected  = (devhead_r[SSR_DH_DEV] == DEVICE_NUMBER);
    assign cmd_wr    = cb_wr && (hbus.addr == SSR_IDX_STAT_CMD) && selected && !software_reset_bit_r;
    assign status_rd = cb_rd && (hbus.addr == SSR_IDX_STAT_CMD);
    assign cmd_ext   = ssr_is_ext(hbus.wdata);
    assign ld_en     = result.done && busy_r && !software_reset_bit_r;
    assign ld_prev   = last_ext_r;

    // ************************************************************
    // Shadow bytes with previous content
    // ************************************************************
    // Address and count registers each hold a current and previous byte
    ssr_shadow_byte u_count (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .wr_en        (cb_wr && hbus.addr == SSR_IDX_COUNT),
        .wdata        (hbus.wdata),
        .load_en      (ld_en),
        .load_prev_en (ld_prev),
        .load_cur     (result.failed ? result.remain[7:0] : 8'h00),
        .load_prev    (result.failed ? result.remain[15:8] : 8'h00),
        .cur_r        (cnt_cur),
        .prev_r       (cnt_prev)
    );

    ssr_shadow_byte u_lba_low (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .wr_en        (cb_wr && hbus.addr == SSR_IDX_LBA_LOW),
        .wdata        (hbus.wdata),
        .load_en      (ld_en),
        .load_prev_en (ld_prev),
        .load_cur     (result.lba[7:0]),
        .load_prev    (result.lba[31:24]),
        .cur_r        (low_cur),
        .prev_r       (low_prev)
    );

    ssr_shadow_byte u_lba_mid (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .wr_en        (cb_wr && hbus.addr == SSR_IDX_LBA_MID),
        .wdata        (hbus.wdata),
        .load_en      (ld_en),
        .load_prev_en (ld_prev),
        .load_cur     (result.lba[15:8]),
        .load_prev    (result.lba[39:32]),
        .cur_r        (mid_cur),
        .prev_r       (mid_prev)
    );

    ssr_shadow_byte u_lba_high (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .wr_en        (cb_wr && hbus.addr == SSR_IDX_LBA_HIGH),
        .wdata        (hbus.wdata),
        .load_en      (ld_en),
        .load_prev_en (ld_prev),
        .load_cur     (result.lba[23:16]),
        .load_prev    (result.lba[47:40]),
        .cur_r        (high_cur),
        .prev_r       (high_prev)
    );

    // Features is write-only and never reloaded by the engine
    ssr_shadow_byte u_features (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .wr_en        (cb_wr && hbus.addr == SSR_IDX_ERR_FEAT),
        .wdata        (hbus.wdata),
        .load_en      (1'b0),
        .load_prev_en (1'b0),
        .load_cur     (8'h00),
        .load_prev    (8'h00),
        .cur_r        (feat_cur),
        .prev_r       (feat_prev)
    );

    // Power-on settle before the ready bit rises; commands are not held off
    ssr_ready_timer u_ready (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .ready_r (ready)
    );

    // ************************************************************
    // Device control register
    // ************************************************************
    // Reset and interrupt-disable bits written by the host
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            software_reset_bit_r <= 1'b0;
            interrupt_disable_r <= 1'b0;
        end else if (ctl_wr) begin
            software_reset_bit_r <= hbus.wdata[SSR_CTL_SOFTWARE_RESET_BIT];
            interrupt_disable_r <= hbus.wdata[SSR_CTL_INTERRUPT_DISABLE];
        end
    end

    // High-order-byte select; a command-block write always drops it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hob_r <= 1'b0;
        end else if (cb_wr) begin
            hob_r <= 1'b0;
        end else if (ctl_wr) begin
            hob_r <= hbus.wdata[SSR_CTL_HOB];
        end
    end

    assign soft_reset = software_reset_bit_r;

    // ************************************************************
    // Device/head register
    // ************************************************************
    // Head bits follow the final address only for 28-bit commands
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            devhead_r <= SSR_DEVHEAD_RST;
        end else if (cb_wr && hbus.addr == SSR_IDX_DEVHEAD) begin
            devhead_r <= hbus.wdata;
        end else if (ld_en && !last_ext_r) begin
            devhead_r[3:0] <= result.lba[27:24];
        end
    end

    // ************************************************************
    // Command launch
    // ************************************************************
    // The command runs from the write itself, with parameters as they stand
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_start_r <= 1'b0;
            last_ext_r  <= 1'b0;
            cmd_r       <= '0;
        end else begin
            cmd_start_r <= cmd_wr;
            if (cmd_wr) begin
                last_ext_r        <= cmd_ext;
                cmd_r.code        <= hbus.wdata;
                cmd_r.features    <= feat_cur;
                cmd_r.lba_mode    <= devhead_r[SSR_DH_LBA];
                cmd_r.drive       <= devhead_r[SSR_DH_DEV];
                cmd_r.ext         <= cmd_ext;
                // Parameters are taken as loaded; host loads them first
                if (cmd_ext) begin
                    cmd_r.count   <= {cnt_prev, cnt_cur};
                    cmd_r.lba     <= {high_prev, mid_prev, low_prev,
                                      high_cur, mid_cur, low_cur};
                    cmd_r.sectors <= ({cnt_prev, cnt_cur} == 16'h0000) ?
                                     SSR_SECT_48_MAX : {1'b0, cnt_prev, cnt_cur};
                end else begin
                    cmd_r.count   <= {8'h00, cnt_cur};
                    cmd_r.lba     <= {20'h00000, devhead_r[3:0],
                                      high_cur, mid_cur, low_cur};
                    cmd_r.sectors <= (cnt_cur == 8'h00) ?
                                     SSR_SECT_28_MAX : {9'h000, cnt_cur};
                end
            end
        end
    end

    // ************************************************************
    // Busy and command state
    // ************************************************************
    // Last cycle's reset bit; its fall is what re-enables the device
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            software_reset_bit_d_r <= 1'b0;
        end else begin
            software_reset_bit_d_r <= software_reset_bit_r;
        end
    end

    // Busy from command write to completion, and throughout soft reset
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
        end else if (software_reset_bit_r) begin
            busy_r <= 1'b1;
        end else if (cmd_wr) begin
            busy_r <= 1'b1;
        end else if (ld_en || software_reset_bit_d_r) begin
            busy_r <= 1'b0;
        end
    end

    // ************************************************************
    // Error register and error bit
    // ************************************************************
    // Cleared on a new command, loaded from the completion report
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            error_r <= 8'h00;
            err_r   <= 1'b0;
        end else if (software_reset_bit_r || cmd_wr) begin
            error_r <= 8'h00;
            err_r   <= 1'b0;
        end else if (ld_en) begin
            error_r[SSR_ERR_LINK_CRC_ERROR] <= result.crc;
            error_r[SSR_ERR_UNC]  <= result.uncorrectable_error;
            error_r[SSR_ERR_IDNF] <= result.idnf;
            error_r[SSR_ERR_COMMAND_ABORTED] <= result.abort;
            err_r                 <= result.failed || result.crc || result.uncorrectable_error
                                     || result.idnf || result.abort;
        end
    end

    // ************************************************************
    // Fault flag and interrupt
    // ************************************************************
    // Status read clears these, the fault flag only when not busy; a new event in that cycle wins
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            df_r       <= 1'b0;
            irq_pend_r <= 1'b0;
        end else begin
            if (ld_en && result.fault) begin
                df_r <= 1'b1;
            end else if (status_rd && !busy_r) begin
                df_r <= 1'b0;
            end
            if (ld_en) begin
                irq_pend_r <= 1'b1;
            end else if (status_rd || software_reset_bit_r) begin
                irq_pend_r <= 1'b0;
            end
        end
    end

    // Only the selected device with interrupts enabled may raise the line
    assign intrq       = irq_pend_r && !interrupt_disable_r && selected;
    assign frame_i_bit = irq_pend_r || interrupt_disable_r;

    // ************************************************************
    // Read path
    // ************************************************************
    // Seek-complete shows ready since there is no mechanism to settle
    always_comb begin
        status_byte                = 8'h00;
        status_byte[SSR_ST_BSY]    = busy_r;
        status_byte[SSR_ST_DEVICE_READY_FLAG]   = ready && !software_reset_bit_r;
        status_byte[SSR_ST_DF]     = df_r;
        status_byte[SSR_ST_DSC]    = ready && !software_reset_bit_r;
        status_byte[SSR_ST_DRQ]    = drq_in && !busy_r;
        status_byte[SSR_ST_CORRECTED_DATA_FLAG]   = 1'b0;
        status_byte[SSR_ST_ERR]    = err_r;
    end

    // Registered read data; busy turns every read into a status read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata_r <= 8'h00;
        end else if (hbus.rd) begin
            if (busy_r || hbus.ctl_sel) begin
                host_rdata_r <= status_byte;
            end else begin
                unique case (hbus.addr)
                    SSR_IDX_ERR_FEAT: host_rdata_r <= error_r;
                    SSR_IDX_COUNT:    host_rdata_r <= hob_r ? cnt_prev : cnt_cur;
                    SSR_IDX_LBA_LOW:  host_rdata_r <= hob_r ? low_prev : low_cur;
                    SSR_IDX_LBA_MID:  host_rdata_r <= hob_r ? mid_prev : mid_cur;
                    SSR_IDX_LBA_HIGH: host_rdata_r <= hob_r ? high_prev : high_cur;
                    SSR_IDX_DEVHEAD:  host_rdata_r <= devhead_r;
                    SSR_IDX_STAT_CMD: host_rdata_r <= status_byte;
                    default:          host_rdata_r <= 8'h00;  // Data port not in this block
                endcase
            end
        end
    end

endmodule : ssr_shadow_regs
`default_nettype wire

// ===== core/ssr_pkg.sv
package ssr_pkg;

    // ************************************************************
    // Register indices on the host register port
    // ************************************************************
    localparam logic [2:0] SSR_IDX_ERR_FEAT = 3'h1;  // Read error_flags, write features
    localparam logic [2:0] SSR_IDX_COUNT    = 3'h2;
    localparam logic [2:0] SSR_IDX_LBA_LOW  = 3'h3;
    localparam logic [2:0] SSR_IDX_LBA_MID  = 3'h4;
    localparam logic [2:0] SSR_IDX_LBA_HIGH = 3'h5;
    localparam logic [2:0] SSR_IDX_DEVHEAD  = 3'h6;
    localparam logic [2:0] SSR_IDX_STAT_CMD = 3'h7;  // Read device_status, write command
    localparam logic [2:0] SSR_IDX_CTL      = 3'h6;  // With ctl_sel: device_control / alt status

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SSR_CTL_HOB   = 7;
    localparam int SSR_CTL_SOFTWARE_RESET_BIT  = 2;
    localparam int SSR_CTL_INTERRUPT_DISABLE  = 1;
    localparam int SSR_DH_LBA    = 6;
    localparam int SSR_DH_DEV    = 4;
    localparam int SSR_ERR_LINK_CRC_ERROR  = 7;
    localparam int SSR_ERR_UNC   = 6;
    localparam int SSR_ERR_IDNF  = 4;
    localparam int SSR_ERR_COMMAND_ABORTED  = 2;
    localparam int SSR_ST_BSY    = 7;
    localparam int SSR_ST_DEVICE_READY_FLAG   = 6;
    localparam int SSR_ST_DF     = 5;
    localparam int SSR_ST_DSC    = 4;
    localparam int SSR_ST_DRQ    = 3;
    localparam int SSR_ST_CORRECTED_DATA_FLAG   = 2;
    localparam int SSR_ST_ERR    = 0;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [7:0]  SSR_DEVHEAD_RST = 8'h80;  // Bit 7 reads as one
    localparam logic [7:0]  SSR_SHADOW_RST  = 8'h00;
    localparam logic [7:0]  SSR_CODE_RST    = 8'h00;
    localparam logic [16:0] SSR_SECT_28_MAX = 17'h00100;  // 256
    localparam logic [16:0] SSR_SECT_48_MAX = 17'h10000;  // 65,536
    localparam int          SSR_CLK_NS      = 10;
    localparam int          SSR_READY_NS    = 1000;
    localparam int          SSR_READY_CYC   = (SSR_READY_NS + SSR_CLK_NS - 1) / SSR_CLK_NS;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic       wr;       // One-cycle write strobe
        logic       rd;       // One-cycle read strobe
        logic       ctl_sel;  // Selects the control block instead of command block
        logic [2:0] addr;
        logic [7:0] wdata;
    } ssr_hbus_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [7:0]  features;
        logic [15:0] count;
        logic [47:0] lba;
        logic [16:0] sectors;  // Count with zero already expanded
        logic        lba_mode;
        logic        ext;
        logic        drive;
    } ssr_cmd_t;

    typedef struct packed {
        logic        done;     // One-cycle completion strobe
        logic        failed;
        logic        crc;
        logic        uncorrectable_error;
        logic        idnf;
        logic        abort;
        logic        fault;
        logic [47:0] lba;      // Current address at completion
        logic [15:0] remain;   // Sectors still to transfer
    } ssr_result_t;

    // Command codes that use 48-bit addressing
    function automatic logic ssr_is_ext(input logic [7:0] code);
        case (code)
            8'h24, 8'h25, 8'h27, 8'h29, 8'h2f, 8'h34,
            8'h35, 8'h37, 8'h39, 8'h3f, 8'h42, 8'hea: ssr_is_ext = 1'b1;
            default:                                 ssr_is_ext = 1'b0;
        endcase
    endfunction : ssr_is_ext

endpackage : ssr_pkg

// ===== core/ssr_shadow_byte.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_shadow_byte (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Host write
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // Completion load
    input  wire logic       load_en,
    input  wire logic       load_prev_en,
    input  wire logic [7:0] load_cur,
    input  wire logic [7:0] load_prev,
    // Contents
    output logic      [7:0] cur_r,
    output logic      [7:0] prev_r
);
    import ssr_pkg::*;

    // A host write pushes the latest value into the previous slot
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_r  <= SSR_SHADOW_RST;
            prev_r <= SSR_SHADOW_RST;
        end else if (wr_en) begin
            prev_r <= cur_r;
            cur_r  <= wdata;
        end else if (load_en) begin
            cur_r <= load_cur;
            if (load_prev_en) begin
                prev_r <= load_prev;
            end
        end
    end

endmodule : ssr_shadow_byte
`default_nettype wire

// ===== core/ssr_ready_timer.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_ready_timer (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Ready after power-on settle
    output logic      ready_r
);
    import ssr_pkg::*;

    localparam int CW = $clog2(SSR_READY_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(SSR_READY_CYC - 1);

    logic [CW-1:0] cnt_r;

    // Counts once after reset; ready never drops again until reset
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r   <= '0;
            ready_r <= 1'b0;
        end else if (!ready_r) begin
            cnt_r <= cnt_r + CW'(1);
            if (cnt_r == LAST) begin
                ready_r <= 1'b1;
            end
        end
    end

endmodule : ssr_ready_timer
`default_nettype wire

// ===== verification/ssr_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_monitor (
    // Clock, reset and host port
    input  wire logic               mclk, sys_rst,
    input  wire ssr_pkg::ssr_hbus_t hbus,
    input  wire logic         [7:0] host_rdata_r,
    // Outputs watched
    input  wire logic               intrq, frame_i_bit, cmd_start_r, soft_reset,
    input  wire ssr_pkg::ssr_cmd_t  cmd_r
);
    import ssr_pkg::*;
    logic interrupt_disable_r;
    wire  cmd_wr = hbus.wr && !hbus.ctl_sel && hbus.addr == SSR_IDX_STAT_CMD;
    wire  ctl_wr = hbus.wr && hbus.ctl_sel && hbus.addr == SSR_IDX_CTL;
    wire  st_rd  = hbus.rd && (hbus.ctl_sel || hbus.addr == SSR_IDX_STAT_CMD);
    // Shadow of the disable bit; control writes are never refused
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) interrupt_disable_r <= 1'b0;
        else if (ctl_wr) interrupt_disable_r <= hbus.wdata[SSR_CTL_INTERRUPT_DISABLE];
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    start_cause_a: assert property (cmd_start_r |-> $past(cmd_wr)) else $error("stray start");
    software_reset_bit_follow_a: assert property (
        ctl_wr |=> soft_reset == $past(hbus.wdata[SSR_CTL_SOFTWARE_RESET_BIT])) else $error("reset bit lost");
    software_reset_bit_block_a: assert property (soft_reset && cmd_wr |=> !cmd_start_r) else $error("start in reset");
    software_reset_bit_busy_a: assert property (
        soft_reset && $past(soft_reset) && hbus.rd |=> host_rdata_r[7])
        else $error("not busy in reset");
    interrupt_disable_frame_a: assert property (interrupt_disable_r |-> frame_i_bit && !intrq) else $error("irq not gated");
    zero_count_a: assert property (cmd_start_r && (cmd_r.ext ? cmd_r.count == 16'h0000
        : cmd_r.count[7:0] == 8'h00) |-> cmd_r.sectors == (cmd_r.ext ? SSR_SECT_48_MAX
        : SSR_SECT_28_MAX)) else $error("zero count");
    corrected_data_flag_zero_a: assert property (st_rd |=> !host_rdata_r[SSR_ST_CORRECTED_DATA_FLAG]) else $error("corrected_data_flag set");
    err_clear_a: assert property (cmd_start_r ##1 st_rd |=> !host_rdata_r[SSR_ST_ERR])
        else $error("error kept");
    cover property (cmd_start_r && cmd_r.ext);
    cover property (soft_reset && cmd_wr);
    cover property (interrupt_disable_r && frame_i_bit);
endmodule : ssr_monitor
bind ssr_shadow_regs ssr_monitor u_mon (.mclk, .sys_rst, .hbus, .host_rdata_r, .intrq,
    .frame_i_bit, .cmd_start_r, .soft_reset, .cmd_r);
`default_nettype wire

// ===== verification/ssr_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssr_engine_model (
    input  wire logic                 mclk, sys_rst, start,
    input  wire logic           [4:0] lat,
    input  wire ssr_pkg::ssr_result_t plan,
    output var  ssr_pkg::ssr_result_t result
);
    logic [4:0] wait_r;
    // One done per start; fields show junk between answers, as a real engine may
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= 5'h00;
            result <= '0;
        end else begin
            result      <= (wait_r == 5'h01) ? plan : ~plan;
            result.done <= (wait_r == 5'h01);
            wait_r      <= start ? lat : wait_r - 5'(wait_r != 5'h00);
        end
    end
endmodule : ssr_engine_model
`default_nettype wire

// ===== verification/ata_shadow_register_block_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module ata_shadow_register_block_tb;
    import ssr_pkg::*;
    logic        mclk = 1'b0, sys_rst = 1'b1, intrq, frame_i_bit, cmd_start_r, soft_reset;
    logic  [4:0] lat = 5'h08;
    logic  [7:0] host_rdata_r, rd_v, b [8];
    logic [16:0] lfsr = 17'h15cc7;  // Seed 89287
    ssr_hbus_t   hbus = '0;
    ssr_cmd_t    cmd_r;
    ssr_result_t plan = '0, result;
    int          num_errors = 0, checked = 0, starts = 0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (cmd_start_r === 1'b1) starts++;
    // Data request tied low, so no command is ever written under it
    ssr_shadow_regs u_dut (.mclk, .sys_rst, .hbus, .host_rdata_r, .intrq, .frame_i_bit,
        .cmd_start_r, .cmd_r, .soft_reset, .drq_in(1'b0), .result);
    ssr_engine_model u_eng (.mclk, .sys_rst, .start(cmd_start_r), .lat, .plan, .result);
    function automatic logic [7:0] rnd();
        repeat (8) lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
        return lfsr[7:0];
    endfunction : rnd
    // Count, low, mid, high, device/head as they must read after completion
    function automatic logic [7:0] exp_reg(input int k, input int r);
        if (r == 0) return (k == 0) ? plan.remain[7:0] : 8'h00;
        if (r == 4) return {1'b1, k == 0, 2'b00, (k == 1) ? plan.lba[27:24] : b[0][3:0]};
        return plan.lba[8 * (r - 1) +: 8];
    endfunction : exp_reg
    // One access, then an idle cycle so strobes never toggle twice in a step
    task automatic acc(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
        hbus <= '{w, !w, c, a, d};
        @(posedge mclk) #1 hbus <= '0;
        rd_v = host_rdata_r;
        @(posedge mclk) #1;
    endtask : acc
    task automatic settle();
        for (int i = 0; i < 40 && result.done !== 1'b1; i++) @(posedge mclk) #1;
        @(posedge mclk) #1;
    endtask : settle
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        #100000 num_errors++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b0;
        acc(0, 1, SSR_IDX_CTL, 8'h00);
        `CHK(rd_v[SSR_ST_DEVICE_READY_FLAG], 1'b0)
        repeat (SSR_READY_CYC) @(posedge mclk);
        #1 acc(0, 1, SSR_IDX_CTL, 8'h00);
        `CHK(rd_v[SSR_ST_DEVICE_READY_FLAG], 1'b1)
        // 48-bit failing command, then 28-bit zero-count success
        for (int k = 0; k < 2; k++) begin
            foreach (b[i]) b[i] = rnd();
            plan = '{1'b0, k == 0, k == 0, k == 0, 1'b0, k == 0, k == 0,
                {b[7], b[1], b[6], b[2], b[5], b[3]}, {b[4], b[0]}};
            lat <= 5'h08 + 5'(rnd() % 8);
            for (int r = 0; r < 8; r++) acc(1, 0, 3'(SSR_IDX_COUNT + r % 4),
                (k == 1 && r == 4) ? 8'h00 : b[r]);
            acc(1, 0, SSR_IDX_DEVHEAD, {1'b1, k == 0, 2'b00, b[0][3:0]});
            acc(1, 0, SSR_IDX_STAT_CMD, (k == 0) ? 8'h24 : 8'h20);
            acc(0, 0, SSR_IDX_STAT_CMD, 8'h00);
            `CHK({starts, rd_v[SSR_ST_BSY]}, {k + 1, 1'b1})
            `CHK({cmd_r.lba_mode, cmd_r.drive, cmd_r.lba[23:0]}, {k == 0, 1'b0, b[7], b[6], b[5]})
            if (k == 0) `CHK({cmd_r.lba[47:24], cmd_r.count}, {b[3], b[2], b[1], b[0], b[4]})
            settle();
            `CHK(intrq, 1'b1)
            acc(0, 0, SSR_IDX_ERR_FEAT, 8'h00);
            `CHK({rd_v[SSR_ERR_LINK_CRC_ERROR], rd_v[SSR_ERR_UNC], rd_v[SSR_ERR_COMMAND_ABORTED]}, {3{k == 0}})
            for (int r = 0; r < 5; r++) begin
                acc(0, 0, 3'(SSR_IDX_COUNT + r), 8'h00);
                `CHK(rd_v, exp_reg(k, r))
            end
            acc(0, 0, SSR_IDX_STAT_CMD, 8'h00);
            `CHK({rd_v[SSR_ST_DF], rd_v[SSR_ST_ERR]}, {k == 0, k == 0})
            acc(0, 0, SSR_IDX_STAT_CMD, 8'h00);
            `CHK({intrq, rd_v[SSR_ST_DF]}, 2'b00)
        end
        // Earlier byte under high select, current one after a command-block write
        acc(1, 0, SSR_IDX_LBA_LOW, 8'h5a);
        acc(1, 0, SSR_IDX_LBA_LOW, 8'ha5);
        acc(1, 1, SSR_IDX_CTL, 8'h80);
        acc(0, 0, SSR_IDX_LBA_LOW, 8'h00);
        `CHK(rd_v, 8'h5a)
        acc(1, 0, SSR_IDX_ERR_FEAT, 8'h00);
        acc(0, 0, SSR_IDX_LBA_LOW, 8'h00);
        `CHK(rd_v, 8'ha5)
        acc(1, 1, SSR_IDX_CTL, 8'h02);
        `CHK(frame_i_bit, 1'b1)
        acc(1, 0, SSR_IDX_STAT_CMD, 8'h20);
        settle();
        `CHK(intrq, 1'b0)
        acc(1, 0, SSR_IDX_DEVHEAD, 8'h10);
        acc(1, 0, SSR_IDX_STAT_CMD, 8'h20);
        `CHK(starts, 3)
        acc(1, 1, SSR_IDX_CTL, 8'h04);
        acc(1, 0, SSR_IDX_STAT_CMD, 8'h20);
        acc(0, 0, SSR_IDX_LBA_LOW, 8'h00);
        `CHK({starts, rd_v[SSR_ST_BSY]}, {32'd3, 1'b1})
        acc(1, 1, SSR_IDX_CTL, 8'h00);
        repeat (4) @(posedge mclk);
        #1 acc(0, 0, SSR_IDX_STAT_CMD, 8'h00);
        `CHK(rd_v[SSR_ST_BSY], 1'b0)
        print_verdict();
    end
endmodule : ata_shadow_register_block_tb
`default_nettype wire
